// ---- pkg/fdmac_pkg.sv ----
// package for the multiply-accumulate slice: widths, modes, carrier structs
// assumes a single clk_sys domain; no bus, no registers reached by software
package fdmac_pkg;

  // ==========================================================
  // mode encoding
  typedef enum logic [3:0] {
    FDMAC_MODE_NORMAL = 4'h1,
    FDMAC_MODE_DUAL = 4'h2,
    FDMAC_MODE_QUAD = 4'h4,
    FDMAC_MODE_FLOAT = 4'h8
  } fdmac_mode_e;

  // ==========================================================
  // operand and result widths
  localparam int unsigned FDMAC_A_W = 19;
  localparam int unsigned FDMAC_B_W = 18;
  localparam int unsigned FDMAC_ACC_W = 48;
  localparam int unsigned FDMAC_SH_W = 4;
  localparam int unsigned FDMAC_D_A_W = 11;
  localparam int unsigned FDMAC_D_B_W = 10;
  localparam int unsigned FDMAC_D8_W = 8;
  localparam int unsigned FDMAC_DACC_W = 24;
  localparam int unsigned FDMAC_Q_A_W = 7;
  localparam int unsigned FDMAC_Q_B_W = 6;
  localparam int unsigned FDMAC_Q4_W = 4;
  localparam int unsigned FDMAC_QACC_W = 12;
  localparam int unsigned FDMAC_BF_W = 16;
  // lane field bases inside the packed operand words
  localparam int unsigned FDMAC_LANE1_A = 11;
  localparam int unsigned FDMAC_LANE1_B = 10;
  localparam int unsigned FDMAC_QL_A = 7;
  localparam int unsigned FDMAC_QL_B = 6;
  // bfloat16 layout
  localparam int unsigned FDMAC_BF_EXP_W = 8;
  localparam int unsigned FDMAC_BF_MAN_W = 7;
  localparam logic [7:0] FDMAC_BF_BIAS = 8'h7F;

  // ==========================================================
  // operation select carried with each request
  typedef struct packed {
    logic use_add;     // product feeds adder, else bypass
    logic subtract;    // adder subtracts instead of adding
    logic accumulate;  // adder second term is the running result
  } fdmac_op_s;

  // operand group from the fabric
  typedef struct packed {
    logic [FDMAC_A_W-1:0] a;
    logic [FDMAC_B_W-1:0] b;
    logic [FDMAC_ACC_W-1:0] c;
    logic [FDMAC_SH_W-1:0] shift;
  } fdmac_in_s;

endpackage : fdmac_pkg

// ---- src/fdmac_lane.sv ----
// one integer multiply / add-sub / accumulate / right-shift lane
// assumes operands already sliced and zero-filled by the caller
`timescale 1ns/1ps
module fdmac_lane #(
  parameter int unsigned AW = 19,
  parameter int unsigned BW = 18,
  parameter int unsigned RW = 48
) (
  input wire logic [AW-1:0] a,
  input wire logic [BW-1:0] b,
  input wire logic [RW-1:0] c,
  input wire logic [RW-1:0] acc,
  input wire logic [fdmac_pkg::FDMAC_SH_W-1:0] shift,
  input wire logic signed_mode,
  input wire fdmac_pkg::fdmac_op_s op,
  output logic [RW-1:0] result
);

  // ==========================================================
  // multiply, add-sub, shift
  logic signed [AW:0] a_x;
  logic signed [BW:0] b_x;
  logic signed [AW+BW+1:0] prod;
  logic [RW-1:0] prod_t;
  logic [RW-1:0] term;
  logic [RW-1:0] sum;

  always_comb begin
    // sign or zero extend per configuration
    a_x = signed_mode ? {a[AW-1], a} : {1'b0, a};
    b_x = signed_mode ? {b[BW-1], b} : {1'b0, b};
    prod = a_x * b_x;
    // sign-extend a narrow product, truncate a wide one to lane width
    prod_t = RW'(prod);
    term = op.accumulate ? acc : c;
    if (!op.use_add) begin
      sum = prod_t;
    end else if (op.subtract) begin
      sum = term - prod_t;
    end else begin
      sum = term + prod_t;
    end
    // variable right shift, arithmetic when signed
    if (signed_mode) begin
      result = RW'($signed(sum) >>> shift);
    end else begin
      result = sum >> shift;
    end
  end

endmodule : fdmac_lane

// ---- src/fdmac_top.sv ----
// multiply-accumulate slice: four modes, integer lanes and bfloat16 path
// assumes operands from fabric logic on clk_sys, static mode and signedness
`timescale 1ns/1ps
module fdmac_top #(
  parameter fdmac_pkg::fdmac_mode_e MODE = fdmac_pkg::FDMAC_MODE_NORMAL,
  parameter bit SIGNED_MODE = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire fdmac_pkg::fdmac_in_s din,
  input wire fdmac_pkg::fdmac_op_s op,
  output logic [fdmac_pkg::FDMAC_ACC_W-1:0] result,
  output logic result_valid
);

  localparam int unsigned RW = fdmac_pkg::FDMAC_ACC_W;
  localparam int unsigned DW = fdmac_pkg::FDMAC_DACC_W;
  localparam int unsigned QW = fdmac_pkg::FDMAC_QACC_W;
  localparam int unsigned BFW = fdmac_pkg::FDMAC_BF_W;
  localparam int unsigned EW = fdmac_pkg::FDMAC_BF_EXP_W;
  localparam int unsigned MW = fdmac_pkg::FDMAC_BF_MAN_W;

  // ==========================================================
  // state: accumulator doubles as the registered result
  typedef struct packed {
    logic [RW-1:0] acc;
    logic valid;
  } fdmac_state_s;

  fdmac_state_s s_q;
  fdmac_state_s s_d;

  // ==========================================================
  // integer lanes
  logic [RW-1:0] n_res;
  logic [DW-1:0] d_res [2];
  logic [QW-1:0] q_res [4];
  logic signed_cfg;

  assign signed_cfg = SIGNED_MODE;

  // normal lane 19x18, 48-bit
  fdmac_lane #(.AW(fdmac_pkg::FDMAC_A_W), .BW(fdmac_pkg::FDMAC_B_W),
    .RW(RW)) u_norm (
    .a(din.a), .b(din.b), .c(din.c), .acc(s_q.acc),
    .shift(din.shift), .signed_mode(signed_cfg), .op(op),
    .result(n_res));

  // dual: 11x10 on low fields, 8x8 above, 24-bit each
  fdmac_lane #(.AW(fdmac_pkg::FDMAC_D_A_W), .BW(fdmac_pkg::FDMAC_D_B_W),
    .RW(DW)) u_dual0 (
    .a(din.a[fdmac_pkg::FDMAC_D_A_W-1:0]),
    .b(din.b[fdmac_pkg::FDMAC_D_B_W-1:0]),
    .c(din.c[DW-1:0]), .acc(s_q.acc[DW-1:0]),
    .shift(din.shift), .signed_mode(signed_cfg), .op(op),
    .result(d_res[0]));

  fdmac_lane #(.AW(fdmac_pkg::FDMAC_D8_W), .BW(fdmac_pkg::FDMAC_D8_W),
    .RW(DW)) u_dual1 (
    .a(din.a[fdmac_pkg::FDMAC_LANE1_A +: fdmac_pkg::FDMAC_D8_W]),
    .b(din.b[fdmac_pkg::FDMAC_LANE1_B +: fdmac_pkg::FDMAC_D8_W]),
    .c(din.c[DW +: DW]), .acc(s_q.acc[DW +: DW]),
    .shift(din.shift), .signed_mode(signed_cfg), .op(op),
    .result(d_res[1]));

  // quad: 7x6 lane truncated to 12 bits, then three 4x4 lanes
  fdmac_lane #(.AW(fdmac_pkg::FDMAC_Q_A_W), .BW(fdmac_pkg::FDMAC_Q_B_W),
    .RW(QW)) u_quad0 (
    .a(din.a[fdmac_pkg::FDMAC_Q_A_W-1:0]),
    .b(din.b[fdmac_pkg::FDMAC_Q_B_W-1:0]),
    .c(din.c[QW-1:0]), .acc(s_q.acc[QW-1:0]),
    .shift(din.shift), .signed_mode(signed_cfg), .op(op),
    .result(q_res[0]));

  genvar gi;
  generate
    for (gi = 1; gi < 4; gi++) begin : g_quad
      fdmac_lane #(.AW(fdmac_pkg::FDMAC_Q4_W),
        .BW(fdmac_pkg::FDMAC_Q4_W), .RW(QW)) u_q4 (
        .a(din.a[fdmac_pkg::FDMAC_QL_A + (gi-1)*fdmac_pkg::FDMAC_Q4_W
          +: fdmac_pkg::FDMAC_Q4_W]),
        .b(din.b[fdmac_pkg::FDMAC_QL_B + (gi-1)*fdmac_pkg::FDMAC_Q4_W
          +: fdmac_pkg::FDMAC_Q4_W]),
        .c(din.c[gi*QW +: QW]), .acc(s_q.acc[gi*QW +: QW]),
        .shift(din.shift), .signed_mode(signed_cfg), .op(op),
        .result(q_res[gi]));
    end
  endgenerate

  // ==========================================================
  // bfloat16 helpers
  // multiply two bfloat16 values, truncating the mantissa
  function automatic logic [BFW-1:0] bf_mul(input logic [BFW-1:0] x,
    input logic [BFW-1:0] y);
    logic [MW:0] mx;
    logic [MW:0] my;
    logic [2*MW+1:0] mp;
    logic [EW+1:0] e;
    logic [MW-1:0] m;
    mx = {1'b1, x[MW-1:0]};
    my = {1'b1, y[MW-1:0]};
    mp = mx * my;
    e = {2'b00, x[BFW-2 -: EW]} + {2'b00, y[BFW-2 -: EW]}
      - {2'b00, fdmac_pkg::FDMAC_BF_BIAS};
    if (mp[2*MW+1]) begin
      m = mp[2*MW -: MW];
      e = e + {{(EW+1){1'b0}}, 1'b1};
    end else begin
      m = mp[2*MW-1 -: MW];
    end
    if (x[BFW-2:MW] == '0 || y[BFW-2:MW] == '0 || e[EW+1]) begin
      bf_mul = {x[BFW-1] ^ y[BFW-1], {(BFW-1){1'b0}}};
    end else if (e[EW]) begin
      bf_mul = {x[BFW-1] ^ y[BFW-1], {EW{1'b1}}, {MW{1'b0}}};
    end else begin
      bf_mul = {x[BFW-1] ^ y[BFW-1], e[EW-1:0], m};
    end
  endfunction : bf_mul

  // add two bfloat16 values, truncating alignment bits
  function automatic logic [BFW-1:0] bf_add(input logic [BFW-1:0] x,
    input logic [BFW-1:0] y);
    logic [BFW-1:0] big;
    logic [BFW-1:0] sml;
    logic [EW-1:0] d;
    logic [MW+2:0] mb;
    logic [MW+2:0] ms;
    logic [MW+2:0] mr;
    logic [EW-1:0] e;
    integer k;
    if (x[BFW-2:0] >= y[BFW-2:0]) begin
      big = x;
      sml = y;
    end else begin
      big = y;
      sml = x;
    end
    d = big[BFW-2:MW] - sml[BFW-2:MW];
    mb = {2'b01, big[MW-1:0], 1'b0};
    ms = (sml[BFW-2:MW] == '0) ? '0 : ({2'b01, sml[MW-1:0], 1'b0} >> d);
    mr = (big[BFW-1] == sml[BFW-1]) ? mb + ms : mb - ms;
    e = big[BFW-2:MW];
    if (big[BFW-2:MW] == '0) begin
      bf_add = sml;
    end else if (mr == '0) begin
      bf_add = '0;
    end else if (mr[MW+2]) begin
      bf_add = {big[BFW-1], EW'(e + 1'b1), mr[MW+1 -: MW]};
    end else begin
      for (k = 0; k < MW + 1; k++) begin
        if (!mr[MW+1] && e != '0) begin
          mr = mr << 1;
          e = e - 1'b1;
        end
      end
      bf_add = {big[BFW-1], e, mr[MW -: MW]};
    end
  endfunction : bf_add

  // multiply truncated to bfloat16, then add, subtract or accumulate
  logic [BFW-1:0] f_prod;
  logic [BFW-1:0] f_term;
  logic [BFW-1:0] f_res;

  always_comb begin
    f_prod = bf_mul(din.a[BFW-1:0], din.b[BFW-1:0]);
    f_term = op.accumulate ? s_q.acc[BFW-1:0] : din.c[BFW-1:0];
    if (!op.use_add) begin
      f_res = f_prod;
    end else if (op.subtract) begin
      f_res = bf_add(f_term, {~f_prod[BFW-1], f_prod[BFW-2:0]});
    end else begin
      f_res = bf_add(f_term, f_prod);
    end
  end

  // ==========================================================
  // next state: pick lanes per mode
  always_comb begin
    s_d = s_q;
    s_d.valid = clk_en;
    if (clk_en) begin
      unique case (MODE)
        fdmac_pkg::FDMAC_MODE_NORMAL: s_d.acc = n_res;
        fdmac_pkg::FDMAC_MODE_DUAL: s_d.acc = {d_res[1], d_res[0]};
        fdmac_pkg::FDMAC_MODE_QUAD:
          s_d.acc = {q_res[3], q_res[2], q_res[1], q_res[0]};
        fdmac_pkg::FDMAC_MODE_FLOAT:
          s_d.acc = {{(RW-BFW){1'b0}}, f_res};
        default: s_d.acc = '0;
      endcase
    end
  end

  // running result register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign result = s_q.acc;
  assign result_valid = s_q.valid;

endmodule : fdmac_top

// ---- sim/fdmac_chk_assertions.sv ----
// checker for the slice ports; result values checked in normal mode only
// assumes one clk_sys domain; bound onto fdmac_top below
`timescale 1ns/1ps
module fdmac_chk #(
  parameter fdmac_pkg::fdmac_mode_e MODE = fdmac_pkg::FDMAC_MODE_NORMAL,
  parameter bit SIGNED_MODE = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire fdmac_pkg::fdmac_in_s din,
  input wire fdmac_pkg::fdmac_op_s op,
  input wire logic [fdmac_pkg::FDMAC_ACC_W-1:0] result,
  input wire logic result_valid
);
  // lane packing differs in the other modes, so values only in normal mode
  localparam bit NORM = (MODE == fdmac_pkg::FDMAC_MODE_NORMAL);
  logic [47:0] pr;
  logic [47:0] base;
  logic [47:0] sum;
  logic [47:0] ex;
  // ==========
  // expected result of the request now on the inputs
  always_comb begin
    if (SIGNED_MODE) pr = $signed(din.a) * $signed(din.b);
    else pr = din.a * din.b;
    base = op.accumulate ? result : din.c;
    sum = op.subtract ? base - pr : base + pr;
    ex = op.use_add ? sum : pr;
    if (SIGNED_MODE) ex = $signed(ex) >>> din.shift;
    else ex = ex >> din.shift;
  end
  // ==========
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_take;
    clk_en ##1 result_valid;
  endsequence
  property p_byp;
    NORM && clk_en && !op.use_add |=> result == $past(ex);
  endproperty
  property p_add;
    NORM && clk_en && op.use_add && !op.subtract && !op.accumulate
      |=> result == $past(ex);
  endproperty
  property p_sub;
    NORM && clk_en && op.use_add && op.subtract && !op.accumulate
      |=> result == $past(ex);
  endproperty
  property p_acc;
    NORM && clk_en && op.use_add && op.accumulate
      |=> result == $past(ex);
  endproperty
  property p_shift;
    NORM && clk_en && din.shift != 4'h0 |=> result == $past(ex);
  endproperty
  property p_valid;
    clk_en |-> s_take;
  endproperty
  property p_hold;
    !clk_en |=> !result_valid && $stable(result);
  endproperty
  property p_rst;
    $rose(reset_n) |-> result == '0 && !result_valid;
  endproperty
  a_byp: assert property (p_byp)
    else $error("bypass product wrong");
  a_add: assert property (p_add)
    else $error("add result wrong");
  a_sub: assert property (p_sub)
    else $error("subtract result wrong");
  a_acc: assert property (p_acc)
    else $error("accumulate result wrong");
  a_shift: assert property (p_shift)
    else $error("shifted result wrong");
  a_valid: assert property (p_valid)
    else $error("valid missing after take");
  a_hold: assert property (p_hold)
    else $error("result moved on idle edge");
  a_rst: assert property (p_rst)
    else $error("result not cleared by reset");
endmodule : fdmac_chk

bind fdmac_top fdmac_chk #(
  .MODE(MODE),
  .SIGNED_MODE(SIGNED_MODE)
) u_chk (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .clk_en(clk_en),
  .din(din),
  .op(op),
  .result(result),
  .result_valid(result_valid)
);

// ---- sim/fdmac_fab.sv ----
// fabric logic model that feeds operands to the slice
// assumes the caller enters issue just after a rising edge
`timescale 1ns/1ps
module fdmac_fab #(
  parameter bit SIGNED_MODE = 1'b1
) (
  input wire logic clk_sys,
  output fdmac_pkg::fdmac_in_s din,
  output fdmac_pkg::fdmac_op_s op,
  output logic clk_en
);
  // ==========
  // idle lines at time zero
  initial begin
    din = '0;
    op = '0;
    clk_en = 1'b0;
  end
  // one request; last releases lines with inverted data
  task automatic issue(input fdmac_pkg::fdmac_in_s v,
                       input fdmac_pkg::fdmac_op_s o, input bit last);
    @(posedge clk_sys);
    din <= v;
    op <= o;
    clk_en <= 1'b1;
    if (last) begin
      @(posedge clk_sys);
      clk_en <= 1'b0;
      din <= ~v;
      op <= ~o;
    end
  endtask : issue
endmodule : fdmac_fab

// ---- sim/tb_top.sv ----
// testbench for the slice in all four modes, signed operands
// assumes fdmac_fab drives operands and the checker is bound
`timescale 1ns/1ps
module tb_top;
  localparam bit SGN = 1'b1;
  localparam fdmac_pkg::fdmac_op_s BYP = 3'h0;
  localparam fdmac_pkg::fdmac_op_s ADD = 3'h4;
  localparam fdmac_pkg::fdmac_op_s SUB = 3'h6;
  localparam fdmac_pkg::fdmac_op_s ACC = 3'h5;
  localparam fdmac_pkg::fdmac_op_s ACS = 3'h7;
  logic clk_sys;
  logic reset_n;
  logic clk_en;
  fdmac_pkg::fdmac_in_s din;
  fdmac_pkg::fdmac_op_s op;
  logic [47:0] result;
  logic result_valid;
  logic [47:0] r_dual;
  logic [47:0] r_quad;
  logic [47:0] r_flt;
  int err_total;
  int n_compared;
  // ==========
  // fabric model and slice
  fdmac_fab #(.SIGNED_MODE(SGN)) u_fab (
    .clk_sys(clk_sys),
    .din(din),
    .op(op),
    .clk_en(clk_en)
  );
  fdmac_top #(.MODE(fdmac_pkg::FDMAC_MODE_NORMAL), .SIGNED_MODE(SGN)) dut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .din(din),
    .op(op),
    .result(result),
    .result_valid(result_valid)
  );
  // the other three modes on the same operand lines
  fdmac_top #(.MODE(fdmac_pkg::FDMAC_MODE_DUAL),
    .SIGNED_MODE(SGN)) dut_dual (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .din(din),
    .op(op), .result(r_dual), .result_valid());
  fdmac_top #(.MODE(fdmac_pkg::FDMAC_MODE_QUAD),
    .SIGNED_MODE(SGN)) dut_quad (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .din(din),
    .op(op), .result(r_quad), .result_valid());
  fdmac_top #(.MODE(fdmac_pkg::FDMAC_MODE_FLOAT),
    .SIGNED_MODE(SGN)) dut_flt (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .din(din),
    .op(op), .result(r_flt), .result_valid());
  // 50 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ==========
  // compare, verdict, single request
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic run(input logic [18:0] a, input logic [17:0] b,
                     input logic [47:0] c, input logic [3:0] s,
                     input fdmac_pkg::fdmac_op_s o, input logic [47:0] e);
    u_fab.issue({a, b, c, s}, o, 1'b1);
    @(negedge clk_sys);
    chk(result, e);
    chk({47'h0, result_valid}, 48'h1);
  endtask : run
  // one request, dual and quad lane results judged
  task automatic run_m(input fdmac_pkg::fdmac_in_s v,
                       input fdmac_pkg::fdmac_op_s o,
                       input logic [47:0] e_d, input logic [47:0] e_q);
    u_fab.issue(v, o, 1'b1);
    @(negedge clk_sys);
    chk(r_dual, e_d);
    chk(r_quad, e_q);
  endtask : run_m
  // one request, bfloat16 result judged
  task automatic run_f(input logic [15:0] a, input logic [15:0] b,
                       input logic [15:0] c, input fdmac_pkg::fdmac_op_s o,
                       input logic [47:0] e);
    u_fab.issue({3'h0, a, 2'h0, b, 32'h0, c, 4'h0}, o, 1'b1);
    @(negedge clk_sys);
    chk(r_flt, e);
  endtask : run_f
  // ==========
  // scenarios
  task automatic t_mult();
    run(19'h7FFFD, 18'h00005, 48'h0, 4'h0, BYP, 48'hFFFFFFFFFFF1);
    run(19'h7FFFF, 18'h00003, 48'h0, 4'h0, BYP, 48'hFFFFFFFFFFFD);
    run(19'h40000, 18'h20000, 48'h0, 4'h0, BYP, 48'h000800000000);
  endtask : t_mult
  task automatic t_addsub();
    run(19'h7FFFD, 18'h00005, 48'h64, 4'h0, ADD, 48'h55);
    run(19'h7FFFD, 18'h00005, 48'h64, 4'h0, SUB, 48'h73);
    run(19'h7FFFD, 18'h00005, 48'h64, 4'h2, SUB, 48'h1C);
    run(19'h7FFFD, 18'h00005, 48'h0, 4'h2, BYP, 48'hFFFFFFFFFFFC);
    run(19'h3FFFF, 18'h1FFFF, 48'h0, 4'hF, BYP, 48'h0000000FFFF4);
  endtask : t_addsub
  // quad 7x6 lane -64*-32 overflows twelve bits; lanes shift on their own
  task automatic t_lanes();
    run_m({19'h7F1C0, 18'h0D4A0, 48'h0, 4'h0}, BYP,
          48'hFFFF96011800, 48'hFFDFF6006800);
    run_m({19'h7F1C0, 18'h0D4A0, 48'h0, 4'h1}, BYP,
          48'hFFFFCB008C00, 48'hFFEFFB003C00);
    run_m({19'h7F1C0, 18'h0D4A0, 48'h000010000001, 4'h0}, ADD,
          48'hFFFFA6011801, 48'hFFD006006801);
  endtask : t_lanes
  // 1.5 times 2.0, then added to and subtracted from 1.0
  task automatic t_float();
    run_f(16'h3FC0, 16'h4000, 16'h3F80, BYP, 48'h4040);
    run_f(16'h3FC0, 16'h4000, 16'h3F80, ADD, 48'h4080);
    run_f(16'h3FC0, 16'h4000, 16'h3F80, SUB, 48'hC000);
  endtask : t_float
  task automatic t_accum();
    u_fab.issue({19'h7, 18'h6, 48'h3E8, 4'h0}, BYP, 1'b0);
    u_fab.issue({19'h2, 18'h3, 48'h3E8, 4'h0}, ACC, 1'b0);
    run(19'h1, 18'h1, 48'h3E8, 4'h0, ACS, 48'h2F);
    repeat (3) @(negedge clk_sys);
    chk(result, 48'h2F);
    chk({47'h0, result_valid}, 48'h0);
  endtask : t_accum
  task automatic t_reset_mid();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    chk(result, 48'h0);
    run(19'h2, 18'h2, 48'h0, 4'h0, BYP, 48'h4);
  endtask : t_reset_mid
  // main sequence
  initial begin
    err_total = 0;
    n_compared = 0;
    reset_n = 1'b0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    chk(result, 48'h0);
    chk({47'h0, result_valid}, 48'h0);
    t_mult();
    t_addsub();
    t_accum();
    t_lanes();
    t_float();
    t_reset_mid();
    results();
  end
  // cut a hang short
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    results();
  end
endmodule : tb_top
